// [rtl/pdc_bank.sv]
// one post-divider bank: source mux and four dividers as clock enables
`timescale 1ns/1ps
`default_nettype none
module pdc_bank
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic vco_en,
  input wire logic ref_en,
  input wire logic [7:0] cfg,
  output logic input_clock,
  output logic div2_en,
  output logic div3_en,
  output logic div4_en,
  output logic divn_en
);
  logic [6:0] cnt_q, cnt_d;
  logic [1:0] c3_q, c3_d;
  logic [1:0] c4_q, c4_d;
  logic [6:0] divisor;

  // ************************************************************
  // source mux
  // ************************************************************
  // [RQ13] [RQ17] select high is vco
  assign input_clock = cfg[pdc_pkg::SRC_SEL_BIT] ? vco_en : ref_en;
  // [RQ16] divisor field
  assign divisor = cfg[6:0];

  // [RQ14] four divide options as one-cycle enables
  always_comb
  begin
    cnt_d = cnt_q;
    c3_d = c3_q;
    c4_d = c4_q;
    if (input_clock)
    begin
      cnt_d = (cnt_q >= divisor - 7'h01) ? 7'h00 : cnt_q + 7'h01;
      c3_d = (c3_q == 2'h2) ? 2'h0 : c3_q + 2'h1;
      c4_d = c4_q + 2'h1;
    end
  end

  assign div2_en = input_clock & c4_q[0];
  assign div3_en = input_clock & (c3_q == 2'h2);
  assign div4_en = input_clock & (c4_q == 2'h3);
  // divisors below 2 fall back to every input edge; not guaranteed anyway
  assign divn_en = input_clock & ((divisor < 7'h02) | (cnt_q >= divisor - 7'h01));

  // counters register
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      cnt_q <= 7'h00;
      c3_q <= 2'h0;
      c4_q <= 2'h0;
    end
    else
    begin
      cnt_q <= cnt_d;
      c3_q <= c3_d;
      c4_q <= c4_d;
    end
  end
endmodule : pdc_bank
`default_nettype wire

// [rtl/pdc_pkg.sv]
// package of constants for the pll divider configuration decode
//
// Function
// [RQ1] reference divided by predivide field plus two, totals 2 to 129
// [RQ2] host keeps divided reference at or above 250 kHz
// [RQ3] feedback total is two times (base plus four) plus odd bit
// [RQ4] base is 10 bits: two from pump register, eight from next
// [RQ5] odd bit comes from bit 7 of predivide register
// [RQ6] feedback total spans 8 to 2055
// [RQ7] host keeps vco between 100 MHz and 400 MHz
// [RQ8] top three pump register bits fixed at 1,1,0
// [RQ9] pump code taken from bits 4 to 2
// [RQ10] host picks pump code from feedback total ranges
// [RQ11] host never programs pump codes 101, 110, 111
// [RQ12] stability not guaranteed for totals below 16 or above 1023
// [RQ13] each bank fed by its own vco or reference select mux
// [RQ14] each bank divides by 2, 3, 4 or its divisor
// [RQ15] host programs each divisor between 4 and 127
// [RQ16] bank register bit 7 select, bits 6:0 divisor
// [RQ17] select high picks vco, low picks reference
// [RQ18] serial target address defaults to hex 69
package pdc_pkg;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] BANK1_POST_DIVIDER_ADDR = 8'h0C;
  localparam logic [7:0] INPUT_LOAD_CAP_ADDR = 8'h13;
  localparam logic [7:0] PUMP_FB_HIGH_ADDR = 8'h40;
  localparam logic [7:0] FB_BASE_LOW_ADDR = 8'h41;
  localparam logic [7:0] ODD_PREDIV_ADDR = 8'h42;
  localparam logic [7:0] BANK2_POST_DIVIDER_ADDR = 8'h47;
  // ************************************************************
  // field positions and fixed values
  // ************************************************************
  localparam int SRC_SEL_BIT = 7;
  localparam int ODD_BIT = 7;
  localparam int PUMP_LSB = 2;
  localparam logic [2:0] PUMP_FIXED_TOP = 3'h6;
  localparam logic [6:0] PREDIV_OFFSET = 7'h02;
  localparam logic [10:0] FB_BASE_OFFSET = 11'h004;
  // reset values are undefined, these are plain working defaults
  localparam logic [7:0] BANK_RESET = 8'h08;
  localparam logic [7:0] PUMP_RESET = 8'hC0;
  localparam logic [7:0] ZERO_RESET = 8'h00;
  localparam logic [6:0] TARGET_ADDR = 7'h69;
  // serial access command states
  typedef enum logic [2:0] {
    PDC_IDLE = 3'b001,
    PDC_ADDR = 3'b010,
    PDC_DATA = 3'b100
  } pdc_state_t;
endpackage : pdc_pkg

// [rtl/pdc_top.sv]
// register file, pll arithmetic and two divider banks
`timescale 1ns/1ps
`default_nettype none
module pdc_top
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic vco_en,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [6:0] target_addr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic [6:0] predivide_total_minus,
  output logic [7:0] predivide_total,
  output logic [11:0] feedback_total,
  output logic [2:0] pump_code,
  output logic [7:0] load_cap_code,
  output logic predivide_en,
  output logic bank1_input_clock,
  output logic bank1_div2_en,
  output logic bank1_div3_en,
  output logic bank1_div4_en,
  output logic bank1_divn_en,
  output logic bank2_input_clock,
  output logic bank2_div2_en,
  output logic bank2_div3_en,
  output logic bank2_div4_en,
  output logic bank2_divn_en
);
  logic [7:0] bank1_q, bank1_d;
  logic [7:0] cap_q, cap_d;
  logic [4:0] pump_q, pump_d;
  logic [7:0] fbl_q, fbl_d;
  logic [7:0] oddq_q, oddq_d;
  logic [7:0] bank2_q, bank2_d;
  logic [7:0] rdat_q, rdat_d;
  logic rval_q, rval_d;
  logic [7:0] qcnt_q, qcnt_d;
  logic sel;
  logic [9:0] feedback_base;
  logic feedback_odd_bit;

  // ************************************************************
  // serial register access
  // ************************************************************
  // [RQ18] only accesses at the target address are answered
  assign sel = (target_addr == pdc_pkg::TARGET_ADDR);

  // register write and read decode
  always_comb
  begin
    bank1_d = bank1_q;
    cap_d = cap_q;
    pump_d = pump_q;
    fbl_d = fbl_q;
    oddq_d = oddq_q;
    bank2_d = bank2_q;
    rdat_d = rdat_q;
    rval_d = 1'b0;
    if (sel && wr_en)
    begin
      unique case (reg_addr)
        pdc_pkg::BANK1_POST_DIVIDER_ADDR: bank1_d = wr_data;
        pdc_pkg::INPUT_LOAD_CAP_ADDR: cap_d = wr_data;
        // [RQ8] top bits are not stored, they cannot change
        pdc_pkg::PUMP_FB_HIGH_ADDR: pump_d = wr_data[4:0];
        pdc_pkg::FB_BASE_LOW_ADDR: fbl_d = wr_data;
        pdc_pkg::ODD_PREDIV_ADDR: oddq_d = wr_data;
        pdc_pkg::BANK2_POST_DIVIDER_ADDR: bank2_d = wr_data;
        default: ;
      endcase
    end
    if (sel && rd_en)
    begin
      rval_d = 1'b1;
      unique case (reg_addr)
        pdc_pkg::BANK1_POST_DIVIDER_ADDR: rdat_d = bank1_q;
        pdc_pkg::INPUT_LOAD_CAP_ADDR: rdat_d = cap_q;
        // [RQ8] fixed top bits read back
        pdc_pkg::PUMP_FB_HIGH_ADDR: rdat_d = {pdc_pkg::PUMP_FIXED_TOP, pump_q};
        pdc_pkg::FB_BASE_LOW_ADDR: rdat_d = fbl_q;
        pdc_pkg::ODD_PREDIV_ADDR: rdat_d = oddq_q;
        pdc_pkg::BANK2_POST_DIVIDER_ADDR: rdat_d = bank2_q;
        default: rdat_d = 8'h00;
      endcase
    end
  end

  // registers hold their values; reset gives a safe working set
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      bank1_q <= pdc_pkg::BANK_RESET;
      cap_q <= pdc_pkg::ZERO_RESET;
      pump_q <= pdc_pkg::PUMP_RESET[4:0];
      fbl_q <= pdc_pkg::ZERO_RESET;
      oddq_q <= pdc_pkg::ZERO_RESET;
      bank2_q <= pdc_pkg::BANK_RESET;
      rdat_q <= 8'h00;
      rval_q <= 1'b0;
    end
    else
    begin
      bank1_q <= bank1_d;
      cap_q <= cap_d;
      pump_q <= pump_d;
      fbl_q <= fbl_d;
      oddq_q <= oddq_d;
      bank2_q <= bank2_d;
      rdat_q <= rdat_d;
      rval_q <= rval_d;
    end
  end

  assign rd_data = rdat_q;
  assign rd_valid = rval_q;
  assign load_cap_code = cap_q;

  // ************************************************************
  // pll arithmetic
  // ************************************************************
  // [RQ4] base from two registers
  assign feedback_base = {pump_q[1:0], fbl_q};
  // [RQ5] odd bit
  assign feedback_odd_bit = oddq_q[pdc_pkg::ODD_BIT];
  // [RQ3] [RQ6] feedback total, 8 to 2055
  assign feedback_total = {({1'b0, feedback_base} + pdc_pkg::FB_BASE_OFFSET), feedback_odd_bit};
  // [RQ9] pump code
  assign pump_code = pump_q[4:pdc_pkg::PUMP_LSB];
  // [RQ1] predivide total
  assign predivide_total_minus = oddq_q[6:0];
  assign predivide_total = {1'b0, oddq_q[6:0]} + {1'b0, pdc_pkg::PREDIV_OFFSET};

  // [RQ1] divide reference (core_clk) by the total
  always_comb
  begin
    qcnt_d = (qcnt_q >= predivide_total - 8'h01) ? 8'h00 : qcnt_q + 8'h01;
  end

  // predivide counter register; a shrinking total wraps through the >= compare
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      qcnt_q <= 8'h00;
    else
      qcnt_q <= qcnt_d;
  end

  assign predivide_en = (qcnt_q >= predivide_total - 8'h01);

  // ************************************************************
  // divider banks
  // ************************************************************
  pdc_bank u_bank1
  (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .vco_en(vco_en),
    .ref_en(1'b1),
    .cfg(bank1_q),
    .input_clock(bank1_input_clock),
    .div2_en(bank1_div2_en),
    .div3_en(bank1_div3_en),
    .div4_en(bank1_div4_en),
    .divn_en(bank1_divn_en)
  );

  pdc_bank u_bank2
  (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .vco_en(vco_en),
    .ref_en(1'b1),
    .cfg(bank2_q),
    .input_clock(bank2_input_clock),
    .div2_en(bank2_div2_en),
    .div3_en(bank2_div3_en),
    .div4_en(bank2_div4_en),
    .divn_en(bank2_divn_en)
  );

  // ************************************************************
  // checks
  // ************************************************************
  fb_range_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ6]
    feedback_total >= 12'h008 && feedback_total <= 12'h807)
    else $error("feedback total out of range");
  fb_formula_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ3]
    feedback_total == 12'(2 * (feedback_base + 4) + feedback_odd_bit))
    else $error("feedback total wrong");
  pre_total_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ1]
    predivide_total == {1'b0, oddq_q[6:0]} + 8'h02)
    else $error("predivide total wrong");
  odd_bit_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ5]
    (sel && wr_en && reg_addr == pdc_pkg::ODD_PREDIV_ADDR)
    |=> feedback_odd_bit == $past(wr_data[7]))
    else $error("odd bit not taken");
  pump_top_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ8]
    (sel && rd_en && reg_addr == 8'h40) |=> rd_data[7:5] == 3'b110)
    else $error("pump fixed bits changed");
  pump_code_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ9]
    (sel && wr_en && reg_addr == 8'h40) |=> pump_code == $past(wr_data[4:2]))
    else $error("pump code not taken");
  bank_mux_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ13]
    bank1_input_clock == (bank1_q[7] ? vco_en : 1'b1))
    else $error("bank1 mux wrong");
  bank_div_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ16]
    (sel && wr_en && reg_addr == 8'h47) |=> bank2_q == $past(wr_data))
    else $error("bank2 register not written");
  addr_sel_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ18]
    (rd_en && target_addr != 7'h69) |=> !rd_valid)
    else $error("foreign address answered");
  // judged per edge, so a rewrite of the total right after a pulse cannot trip it
  pre_pulse_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ1]
    ($past(reset_n) && predivide_total == 8'h02 && $stable(predivide_total))
    |-> predivide_en != $past(predivide_en))
    else $error("predivide by two wrong");
endmodule : pdc_top
`default_nettype wire

// [tb/pdc_host.sv]
// host model that writes and reads the configuration registers
`timescale 1ns/1ps
`default_nettype none
module pdc_host
(
  input wire logic core_clk,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  output logic wr_en,
  output logic rd_en,
  output logic [6:0] target_addr,
  output logic [7:0] reg_addr,
  output logic [7:0] wr_data
);
  // ************************************************************
  // idle levels and access tasks
  // ************************************************************
  initial
  begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    target_addr = 7'h00;
    reg_addr = 8'hFF;
    wr_data = 8'h00;
  end
  // ranges chosen by caller
  // one write strobe; address and data are scrambled once released
  task automatic wr(input logic [6:0] t, input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    target_addr = t;
    reg_addr = a;
    wr_data = d;
    wr_en = 1'b1;
    @(negedge core_clk);
    wr_en = 1'b0;
    reg_addr = ~a;
    wr_data = ~d;
  endtask : wr
  // caller picks the target, default or foreign
  // read strobe; valid and data land one cycle later
  task automatic rd(input logic [6:0] t, input logic [7:0] a, output logic [8:0] v);
    @(negedge core_clk);
    target_addr = t;
    reg_addr = a;
    rd_en = 1'b1;
    @(negedge core_clk);
    v = {rd_valid, rd_data};
    rd_en = 1'b0;
    reg_addr = ~a;
  endtask : rd
endmodule : pdc_host
`default_nettype wire

// [tb/pll_divider_config_decode_tb.sv]
// self-checking testbench for the pll divider configuration decode
`timescale 1ns/1ps
`default_nettype none
module pll_divider_config_decode_tb;
  logic core_clk, reset_n, vco_en, vco_on;
  logic wr_en, rd_en, rd_valid;
  logic [6:0] target_addr, pq;
  logic [7:0] reg_addr, wr_data, rd_data, pt, lc;
  logic [11:0] ft;
  logic [2:0] pc;
  wire logic [10:0] mon;
  logic [8:0] v;
  int err_count, tests_run, cyc, c[11];
  pdc_host host (.core_clk(core_clk), .rd_data(rd_data), .rd_valid(rd_valid),
    .wr_en(wr_en), .rd_en(rd_en), .target_addr(target_addr), .reg_addr(reg_addr),
    .wr_data(wr_data));
  pdc_top DUT (.core_clk(core_clk), .reset_n(reset_n), .vco_en(vco_en), .wr_en(wr_en),
    .rd_en(rd_en), .target_addr(target_addr), .reg_addr(reg_addr), .wr_data(wr_data),
    .rd_data(rd_data), .rd_valid(rd_valid), .predivide_total_minus(pq),
    .predivide_total(pt), .feedback_total(ft), .pump_code(pc), .load_cap_code(lc),
    .predivide_en(mon[0]), .bank1_input_clock(mon[1]), .bank1_div2_en(mon[2]),
    .bank1_div3_en(mon[3]), .bank1_div4_en(mon[4]), .bank1_divn_en(mon[5]),
    .bank2_input_clock(mon[6]), .bank2_div2_en(mon[7]), .bank2_div3_en(mon[8]),
    .bank2_div4_en(mon[9]), .bank2_divn_en(mon[10]));
  // ************************************************************
  // clock, vco ticks every third cycle, timeout
  // ************************************************************
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(negedge core_clk) vco_en <= vco_on && (cyc % 3 == 0);
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      report_and_stop();
    end
  end
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // counts pulses of every monitored enable over n cycles
  task automatic count_run(input int n);
    c = '{default: 0};
    repeat (n)
    begin
      @(negedge core_clk);
      foreach (c[i]) c[i] += int'(mon[i]);
    end
  endtask : count_run
  task automatic report_and_stop();
    if (err_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // ************************************************************
  // scenarios
  // ************************************************************
  // register values right after reset, each read with a valid pulse
  task automatic t_reset();
    logic [7:0] a[6] = '{8'h0C, 8'h47, 8'h40, 8'h13, 8'h41, 8'h42};
    logic [7:0] e[6] = '{8'h08, 8'h08, 8'hC0, 8'h00, 8'h00, 8'h00};
    foreach (a[i])
    begin
      host.rd(7'h69, a[i], v);
      chk("reset read", {3'h0, 1'b1, e[i]}, {3'h0, v});
    end
  endtask : t_reset
  // pll arithmetic for pump codes 0 to 4, both predivide range ends and feedback total 2055
  task automatic t_pll();
    int q[5] = '{0, 127, 5, 1, 10};
    int pb[5] = '{10, 1023, 100, 300, 350};
    int po[5] = '{0, 1, 0, 1, 0};
    int pm[5] = '{0, 4, 1, 2, 3};
    foreach (q[i])
    begin
      host.wr(7'h69, 8'h40, {3'h6, pm[i][2:0], pb[i][9:8]});
      host.wr(7'h69, 8'h41, pb[i][7:0]);
      host.wr(7'h69, 8'h42, {po[i][0], q[i][6:0]});
      chk("predivide", 12'(q[i] + 2), {4'h0, pt});
      chk("predivide field", 12'(q[i]), {5'h00, pq});
      chk("feedback", 12'(2 * (pb[i] + 4) + po[i]), ft);
      chk("pump", 12'(pm[i]), {9'h000, pc});
    end
    host.wr(7'h69, 8'h40, 8'h2B);
    host.rd(7'h69, 8'h40, v);
    chk("pump fixed bits", 12'h1CB, {3'h0, v});
    host.wr(7'h69, 8'h42, 8'h01);
    count_run(60);
    chk("predivide ticks", 12'h014, 12'(c[0]));
  endtask : t_pll
  // both banks from reference and from vco, divisor 5
  task automatic t_bank();
    int e[5] = '{60, 30, 20, 15, 12};
    for (int b = 0; b < 2; b++)
    begin
      for (int s = 0; s < 2; s++)
      begin
        host.wr(7'h69, b ? 8'h47 : 8'h0C, {s[0], 7'h05});
        vco_on = s[0];
        count_run(21);
        count_run(s ? 180 : 60);
        for (int k = 0; k < 5; k++)
          chk("bank count", 12'(e[k]), 12'(c[1 + 5 * b + k]));
      end
    end
  endtask : t_bank
  // other target ignored, unmapped read gives zero
  task automatic t_refuse();
    host.wr(7'h68, 8'h13, 8'h5A);
    chk("other target", 12'h000, {4'h0, lc});
    host.wr(7'h69, 8'h13, 8'h5A);
    host.rd(7'h69, 8'h13, v);
    chk("load cap", 12'h15A, {3'h0, v});
    // foreign read: no valid pulse, read data keeps the last answer
    host.rd(7'h68, 8'h13, v);
    chk("other target read", 12'h05A, {3'h0, v});
    host.rd(7'h69, 8'h43, v);
    chk("unmapped", 12'h100, {3'h0, v});
  endtask : t_refuse
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    reset_n = 1'b0;
    vco_on = 1'b0;
    repeat (12) @(negedge core_clk);
    reset_n = 1'b1;
    t_reset();
    t_pll();
    t_bank();
    t_refuse();
    report_and_stop();
  end
endmodule : pll_divider_config_decode_tb
`default_nettype wire
